// [src/dsw_defines.svh]
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH

// Frame length and bit counter.
`define DSW_CNT_W 5
`define DSW_FRAME_BITS 24
`define DSW_LAST_BIT 5'h17
`define DSW_CNT_FULL 5'h18
`define DSW_CNT_ZERO 5'h00
`define DSW_CNT_ONE 5'h01

// Field positions inside a 24-bit frame, bit 23 first on the wire.
`define DSW_LD_HI 21
`define DSW_LD_LO 20
`define DSW_SEL_HI 18
`define DSW_SEL_LO 17
`define DSW_PD_BIT 16
`define DSW_DATA_HI 15
`define DSW_DATA_LO 2

// Load field codes.
`define DSW_LD_BUF 2'h0
`define DSW_LD_ONE 2'h1
`define DSW_LD_ALL 2'h2
`define DSW_LD_BCAST 2'h3

// Code range and reset values.
`define DSW_CODE_W 14
`define DSW_CHANNELS 4
`define DSW_CODE_ZERO 14'h0000
`define DSW_CODE_FULL 14'h3FFF
`define DSW_WORD_ZERO 24'h000000

`endif

// [src/dsw_pkg.sv]
`include "dsw_defines.svh"

package dsw_pkg;

  // Serial pins seen from the converter side.
  typedef struct packed {
    logic sclk;
    logic sdin;
    logic sync_n;
  } dsw_pins_t;

  typedef logic [`DSW_CODE_W-1:0] dsw_code_t;
  typedef dsw_code_t [`DSW_CHANNELS-1:0] dsw_codes_t;
  typedef logic [`DSW_FRAME_BITS-1:0] dsw_word_t;

  // Frame receive states.
  typedef enum logic [1:0] {
    DSW_ST_IDLE = 2'b00,
    DSW_ST_SHIFT = 2'b01,
    DSW_ST_HOLD = 2'b10
  } dsw_state_t;

endpackage : dsw_pkg

// [src/dsw_port.sv]
// Notes on behaviour
// (RULE1) Host toggles frame select only around clock pulse.
// (RULE2) Toggle without full clock pulse locks port; here the first toggle after reset does not lock, as pulse_seen_q resets high.
// (RULE3) Valid frame or correct toggle releases lock.
// (RULE4) Host keeps frame select free of glitches.
// (RULE5) Byte hosts send three bytes, select low.
// (RULE6) Data travels most significant bit first.
// (RULE7) Host changes data at falling clock edge.
// (RULE8) Standard hosts use polarity 0, phase 1.
// (RULE9) Codes are 14-bit straight binary, 0 to 3FFF.
// (RULE10) 24-bit frame; outputs update after last edge.
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defines.svh"

module dsw_port
  import dsw_pkg::*;
(
  input wire logic clk_sys, // System clock, 125 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire dsw_pins_t pins, // Serial clock, data and frame select pins.
  output var dsw_codes_t dac_code_q, // Loaded converter codes, one per channel.
  output logic update_q, // One-cycle pulse when a frame has loaded.
  output logic locked_q // High while the port is in the locked state.
);

  dsw_pins_t sync1_q, sync2_q, sync3_q, filt_q, filt_d;
  dsw_state_t state_q, state_d;
  logic [`DSW_CNT_W-1:0] cnt_q, cnt_d;
  dsw_word_t shift_q, shift_d;
  dsw_codes_t buf_q, buf_d, dac_code_d;
  logic rise_seen_q, rise_seen_d, pulse_seen_q, pulse_seen_d;
  logic locked_d, update_d, frame_done;
  logic sclk_rise, sclk_fall, sync_fall, sync_rise, sync_edge;
  logic [1:0] ld_f, sel_f;
  dsw_code_t data_f;

  // Pin filter: a pin level is accepted once the second and third stages agree.
  // A level that has not settled through both stages is ignored, so a slow host edge never counts twice.
  always_comb begin
    filt_d = filt_q;
    if (sync2_q.sclk == sync3_q.sclk) filt_d.sclk = sync3_q.sclk;
    if (sync2_q.sdin == sync3_q.sdin) filt_d.sdin = sync3_q.sdin;
    if (sync2_q.sync_n == sync3_q.sync_n) filt_d.sync_n = sync3_q.sync_n;
  end

  // Edges of the filtered pins.
  always_comb begin
    sclk_rise = ~filt_q.sclk & filt_d.sclk;
    sclk_fall = filt_q.sclk & ~filt_d.sclk;
    sync_fall = filt_q.sync_n & ~filt_d.sync_n;
    sync_rise = ~filt_q.sync_n & filt_d.sync_n;
    sync_edge = sync_fall | sync_rise;
  end

  // Pin synchronisers and filtered levels; idle lines reset high for select, low for clock.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q <= '{sclk: 1'b0, sdin: 1'b0, sync_n: 1'b1};
      sync2_q <= '{sclk: 1'b0, sdin: 1'b0, sync_n: 1'b1};
      sync3_q <= '{sclk: 1'b0, sdin: 1'b0, sync_n: 1'b1};
      filt_q <= '{sclk: 1'b0, sdin: 1'b0, sync_n: 1'b1};
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end

  // Clock-pulse tracking between select toggles and lock control.
  // A select edge is judged on pulses already registered, so a clock fall in the same cycle does not count.
  always_comb begin
    rise_seen_d = rise_seen_q;
    pulse_seen_d = pulse_seen_q;
    locked_d = locked_q;
    if (sync_edge) begin
      rise_seen_d = 1'b0;
      pulse_seen_d = 1'b0;
    end else begin
      if (sclk_rise) rise_seen_d = 1'b1;
      if (sclk_fall && rise_seen_q) pulse_seen_d = 1'b1;
    end
    if (frame_done) locked_d = 1'b0; // RULE3
    if (sync_edge && pulse_seen_q) locked_d = 1'b0; // RULE3
    if (sync_edge && !pulse_seen_q) locked_d = 1'b1; // RULE2
  end

  // Frame field decode of the word as it stands after the current edge.
  always_comb begin
    ld_f = shift_d[`DSW_LD_HI:`DSW_LD_LO];
    sel_f = shift_d[`DSW_SEL_HI:`DSW_SEL_LO];
    data_f = shift_d[`DSW_DATA_HI:`DSW_DATA_LO]; // RULE9
  end

  // Frame receiver: shifts on falling clock edges while select is low.
  // Clock edges after the last bit are ignored; a select rise before the last bit drops the frame.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    frame_done = 1'b0;
    case (state_q)
      DSW_ST_IDLE: begin
        if (sync_fall) begin
          state_d = DSW_ST_SHIFT;
          cnt_d = `DSW_CNT_ZERO;
        end
      end
      DSW_ST_SHIFT: begin
        if (sync_rise) begin
          state_d = DSW_ST_IDLE;
        end else if (sclk_fall) begin
          shift_d = {shift_q[`DSW_FRAME_BITS-2:0], filt_q.sdin}; // RULE6
          cnt_d = cnt_q + `DSW_CNT_ONE;
          if (cnt_q == `DSW_LAST_BIT) begin
            frame_done = 1'b1; // RULE10
            state_d = DSW_ST_HOLD;
          end
        end
      end
      DSW_ST_HOLD: begin
        if (sync_rise) state_d = DSW_ST_IDLE;
      end
      default: begin
        state_d = DSW_ST_IDLE;
      end
    endcase
  end

  // Buffer and output load; a frame that completes while locked only releases the lock.
  always_comb begin
    buf_d = buf_q;
    dac_code_d = dac_code_q;
    update_d = 1'b0;
    if (frame_done && !locked_q && !shift_d[`DSW_PD_BIT]) begin // RULE2
      update_d = 1'b1; // RULE10
      buf_d[sel_f] = data_f;
      case (ld_f)
        `DSW_LD_ONE: dac_code_d[sel_f] = data_f; // RULE9
        `DSW_LD_ALL: dac_code_d = buf_d;
        `DSW_LD_BCAST: begin
          for (int i = 0; i < `DSW_CHANNELS; i++) begin
            buf_d[i] = data_f;
            dac_code_d[i] = data_f;
          end
        end
        default: dac_code_d = dac_code_q;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= DSW_ST_IDLE;
      cnt_q <= `DSW_CNT_ZERO;
      shift_q <= `DSW_WORD_ZERO;
      buf_q <= {`DSW_CHANNELS{`DSW_CODE_ZERO}};
      dac_code_q <= {`DSW_CHANNELS{`DSW_CODE_ZERO}};
      rise_seen_q <= 1'b0;
      pulse_seen_q <= 1'b1;
      locked_q <= 1'b0;
      update_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      buf_q <= buf_d;
      dac_code_q <= dac_code_d;
      rise_seen_q <= rise_seen_d;
      pulse_seen_q <= pulse_seen_d;
      locked_q <= locked_d;
      update_q <= update_d;
    end
  end

  default clocking dsw_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  lock_entry_a: assert property (sync_edge && !pulse_seen_q |=> locked_q) // RULE2
    else $error("Select toggle without clock pulse did not lock the port.");

  locked_hold_a: assert property (frame_done && locked_q |=> !update_q && $stable(dac_code_q)) // RULE2
    else $error("Locked port loaded a frame.");

  lock_exit_a: assert property (locked_q && sync_edge && pulse_seen_q |=> !locked_q) // RULE3
    else $error("Correct select toggle did not release the lock.");

  msb_first_a: assert property (state_q == DSW_ST_SHIFT && sclk_fall && !sync_rise // RULE6
    |=> shift_q[0] == $past(filt_q.sdin) && shift_q[`DSW_FRAME_BITS-1:1] == $past(shift_q[`DSW_FRAME_BITS-2:0]))
    else $error("Serial word did not shift most significant bit first.");

  code_map_a: assert property (update_q && shift_q[`DSW_LD_HI:`DSW_LD_LO] == `DSW_LD_ONE // RULE9
    |-> dac_code_q[shift_q[`DSW_SEL_HI:`DSW_SEL_LO]] == shift_q[`DSW_DATA_HI:`DSW_DATA_LO])
    else $error("Loaded code differs from the frame data field.");

  frame_len_a: assert property (frame_done |-> cnt_q == `DSW_LAST_BIT && cnt_d == `DSW_CNT_FULL) // RULE10
    else $error("Frame completed at a bit count other than 24.");

  // Loads happen only for complete, unlocked frames, and the broadcast and load-all modes fill the outputs they name.
  abort_no_load_a: assert property (state_q == DSW_ST_SHIFT && sync_rise |=> state_q == DSW_ST_IDLE && !update_q) // RULE10
    else $error("Frame cut short by select still loaded.");

  pd_no_load_a: assert property (frame_done && shift_d[`DSW_PD_BIT] |=> !update_q && $stable(dac_code_q)) // RULE10
    else $error("Power-down frame changed the loaded codes.");

  bcast_map_a: assert property (update_q && shift_q[`DSW_LD_HI:`DSW_LD_LO] == `DSW_LD_BCAST // RULE9
    |-> dac_code_q == {`DSW_CHANNELS{shift_q[`DSW_DATA_HI:`DSW_DATA_LO]}} && buf_q == dac_code_q)
    else $error("Broadcast frame did not load every channel.");

  all_map_a: assert property (update_q && shift_q[`DSW_LD_HI:`DSW_LD_LO] == `DSW_LD_ALL // RULE9
    |-> dac_code_q == buf_q)
    else $error("Load-all frame did not copy the buffers to the outputs.");

  load_unlocked_a: assert property (update_q |-> $past(!locked_q)) // RULE2
    else $error("Outputs loaded while the port was locked.");

  hold_stable_a: assert property (state_q == DSW_ST_HOLD |=> $stable(shift_q)) // RULE10
    else $error("Bits after the last one entered the frame.");

  update_time_a: assert property (frame_done && !locked_q && !shift_d[`DSW_PD_BIT] |=> update_q ##1 !update_q) // RULE10
    else $error("Outputs did not update one cycle after the last edge.");

endmodule : dsw_port
`default_nettype wire

// [bench/dsw_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defines.svh"

module dsw_host
  import dsw_pkg::*;
(
  input wire logic clk_sys, // Bench clock paces the pins.
  output var dsw_pins_t pins // Pins toward the port.
);
  // Pins idle with clock low and select high.
  initial begin
    pins = '{sclk: 1'b0, sdin: 1'b0, sync_n: 1'b1};
  end

  // Waits on falling bench clock edges.
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : gap

  // One full clock pulse; the caller changes data only while the clock is low.
  task automatic pulse();
    gap(4);
    pins.sclk = 1'b1;
    gap(4);
    pins.sclk = 1'b0;
  endtask : pulse

  // Sends the top bits of a word in bytes under one low select.
  // A leading clock pulse makes the select fall legal; without it the fall is deliberately illegal.
  task automatic send(input dsw_word_t w, input int nbits, input bit lead);
    if (lead) begin
      pulse();
      gap(4);
    end
    pins.sync_n = 1'b0;
    gap(8);
    for (int i = 23; i > 23 - nbits; i--) begin
      if (i % 8 == 7 && i != 23) gap(6);
      pins.sdin = w[i];
      pulse();
    end
    gap(8);
    pins.sync_n = 1'b1;
    pins.sdin = ~pins.sdin;
    gap(8);
  endtask : send

  // Toggles select with no clock pulse between the edges.
  task automatic bad_toggle();
    pins.sync_n = 1'b0;
    gap(8);
    pins.sync_n = 1'b1;
    gap(8);
  endtask : bad_toggle
endmodule : dsw_host
`default_nettype wire

// [bench/dsw_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defines.svh"

module dsw_port_bench
  import dsw_pkg::*;
;
  logic clk_sys;
  logic rst_n;
  dsw_pins_t pins;
  dsw_codes_t dac_code_q;
  logic update_q;
  logic locked_q;
  dsw_codes_t exp_out;
  dsw_codes_t exp_buf;
  int err_count;
  int checked;
  int ups;
  int seed;

  dsw_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .dac_code_q(dac_code_q),
    .update_q(update_q), .locked_q(locked_q));
  dsw_host host (.clk_sys(clk_sys), .pins(pins));

  // Clock at 125 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Counts update pulses over the whole run.
  always @(posedge clk_sys) begin
    if (update_q === 1'b1) ups <= ups + 1;
  end

  // Compares and reports one value.
  task automatic check(input string what, input logic [55:0] e, input logic [55:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Works out the buffers and outputs after an accepted frame.
  function automatic void apply(input dsw_word_t w);
    logic [1:0] sel;
    dsw_code_t d;
    sel = w[`DSW_SEL_HI:`DSW_SEL_LO];
    d = w[`DSW_DATA_HI:`DSW_DATA_LO];
    if (w[`DSW_PD_BIT]) return;
    case (w[`DSW_LD_HI:`DSW_LD_LO])
      `DSW_LD_BUF: exp_buf[sel] = d;
      `DSW_LD_ONE: begin
        exp_buf[sel] = d;
        exp_out[sel] = d;
      end
      `DSW_LD_ALL: begin
        exp_buf[sel] = d;
        exp_out = exp_buf;
      end
      default: begin
        exp_buf = {4{d}};
        exp_out = exp_buf;
      end
    endcase
  endfunction : apply

  // Sends one frame and checks outputs, pulse count and lock.
  task automatic xfer(input dsw_word_t w, input int nbits, input bit lockd);
    bit e;
    int u0;
    e = nbits == 24 && !lockd && !w[`DSW_PD_BIT];
    u0 = ups;
    host.send(w, nbits, !lockd);
    if (nbits == 24 && !lockd) apply(w);
    check("codes", exp_out, dac_code_q);
    check("updates", e, ups - u0);
    check("locked", 0, locked_q);
  endtask : xfer

  // Main sequence: corners, every load mode at random, abort, lock and recovery.
  initial begin
    seed = 32'hD2F71A02;
    rst_n = 1'b0;
    err_count = 0;
    checked = 0;
    exp_out = '0;
    exp_buf = '0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    host.gap(6);
    check("reset codes", '0, dac_code_q);
    xfer({4'h3, 4'h0, `DSW_CODE_FULL, 2'h0}, 24, 0);
    xfer({4'h3, 4'h0, `DSW_CODE_ZERO, 2'h0}, 24, 0);
    for (int k = 0; k < 16; k++) xfer(dsw_word_t'($random(seed)), 24, 0);
    xfer(dsw_word_t'($random(seed)), 20, 0);
    host.bad_toggle();
    check("lock", 1, locked_q);
    xfer(dsw_word_t'($random(seed)), 24, 1);
    xfer({4'h1, 4'h4, `DSW_CODE_FULL, 2'h0}, 24, 0);
    host.bad_toggle();
    check("lock", 1, locked_q);
    xfer(dsw_word_t'($random(seed)), 24, 0);
    rst_n = 1'b0;
    host.gap(4);
    rst_n = 1'b1;
    host.gap(6);
    exp_out = '0;
    exp_buf = '0;
    check("reset codes", '0, dac_code_q);
    xfer({4'h2, 4'h2, `DSW_CODE_FULL, 2'h0}, 24, 0);
    complete_run();
  end
endmodule : dsw_port_bench
`default_nettype wire
